/* rtl/serial_port_pkg.sv */
// Package with constants and types for the RS485 serial port.
package serial_port_pkg;
    localparam int unsigned CLK_HZ = 200000000;
    localparam int unsigned BAUD_MIN = 300;
    localparam int unsigned BAUD_MAX = 250000;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned DIV_W = 20;
    localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / (BAUD_MIN * 16));
    localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / (BAUD_MAX * 16));
    localparam logic [DIV_W-1:0] DIV_RST = DIV_W'(CLK_HZ / (115200 * 16));
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [7:0] BYTE_RST = 8'h00;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_START = 4'b0010,
        S_DATA = 4'b0100,
        S_STOP = 4'b1000
    } line_state_t;
endpackage

/* rtl/byte_fifo.sv */
// Parameterised FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
endmodule

/* rtl/rs485_async_serial_port.sv */
// RS485 asynchronous serial port with independent transmit and buffered receive paths.
`timescale 1ns/100ps
module rs485_async_serial_port
    import serial_port_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Configuration.
    input wire logic [serial_port_pkg::DIV_W-1:0] baud_div_i,
    input wire logic buffered_i,
    input wire logic slave_mode_i,
    // Transceiver pins.
    input wire logic rx_line_i,
    output logic tx_line_o,
    output logic tx_drive_o,
    input wire logic turn_i,
    // Transmit request.
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    // Receive data.
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic frame_err_o,
    output logic overrun_o
);
    import serial_port_pkg::*;

    logic [DIV_W-1:0] div_lim, div_q, div_d;
    logic tick;
    line_state_t tx_st_q, tx_st_d, rx_st_q, rx_st_d;
    logic [3:0] tx_ovs_q, tx_ovs_d, tx_bit_q, tx_bit_d;
    logic [7:0] tx_sh_q, tx_sh_d;
    logic tx_line_q, tx_line_d, tx_rdy_q, tx_rdy_d, drive_q, drive_d;
    logic [3:0] rx_ovs_q, rx_ovs_d, rx_bit_q, rx_bit_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic rx_meta_q, rx_sync_q;
    logic push, fe_q, fe_d, ov_q, ov_d;
    logic [7:0] hold_q, hold_d;
    logic hold_v_q, hold_v_d;
    logic fifo_ready, fifo_valid;
    logic [7:0] fifo_data;
    logic [7:0] out_q, out_d;
    logic out_v_q, out_v_d;
    logic take;

    // Oversampling tick at sixteen times the bit rate.
    always_comb begin
        div_lim = baud_div_i;
        if (baud_div_i > DIV_MAX) begin
            div_lim = DIV_MAX;
        end else if (baud_div_i < DIV_MIN) begin
            div_lim = DIV_MIN;
        end
        tick = (div_q >= div_lim - 1'b1);
        div_d = tick ? '0 : div_q + 1'b1;
    end

    // Transmitter.
    always_comb begin
        tx_st_d = tx_st_q;
        tx_ovs_d = tx_ovs_q;
        tx_bit_d = tx_bit_q;
        tx_sh_d = tx_sh_q;
        tx_line_d = tx_line_q;
        tx_rdy_d = tx_rdy_q;
        case (tx_st_q)
            S_IDLE: begin
                tx_line_d = 1'b1;
                if (tx_valid_i && tx_rdy_q) begin
                    tx_sh_d = tx_data_i;
                    tx_rdy_d = 1'b0;
                    tx_ovs_d = '0;
                    tx_st_d = S_START;
                end
            end
            S_START: begin
                tx_line_d = 1'b0;
                if (tick) begin
                    tx_ovs_d = tx_ovs_q + 1'b1;
                    if (tx_ovs_q == OVS_LAST) begin
                        tx_bit_d = '0;
                        tx_st_d = S_DATA;
                    end
                end
            end
            S_DATA: begin
                tx_line_d = tx_sh_q[0];
                if (tick) begin
                    tx_ovs_d = tx_ovs_q + 1'b1;
                    if (tx_ovs_q == OVS_LAST) begin
                        tx_sh_d = {1'b0, tx_sh_q[7:1]};
                        tx_bit_d = tx_bit_q + 1'b1;
                        if (tx_bit_q == BIT_LAST - 1'b1) begin
                            tx_st_d = S_STOP;
                        end
                    end
                end
            end
            S_STOP: begin
                tx_line_d = 1'b1;
                if (tick) begin
                    tx_ovs_d = tx_ovs_q + 1'b1;
                    if (tx_ovs_q == OVS_LAST) begin
                        tx_rdy_d = 1'b1;
                        tx_st_d = S_IDLE;
                    end
                end
            end
            default: begin
                tx_st_d = S_IDLE;
                tx_rdy_d = 1'b1;
            end
        endcase
        // Slave direction follows turnaround; as master drive only while sending.
        drive_d = slave_mode_i ? turn_i : (tx_st_d != S_IDLE);
    end

    // Receiver.
    always_comb begin
        rx_st_d = rx_st_q;
        rx_ovs_d = rx_ovs_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d = rx_sh_q;
        push = 1'b0;
        fe_d = 1'b0;
        case (rx_st_q)
            S_IDLE: begin
                if (!rx_sync_q) begin
                    rx_ovs_d = '0;
                    rx_st_d = S_START;
                end
            end
            S_START: begin
                if (tick) begin
                    rx_ovs_d = rx_ovs_q + 1'b1;
                    if (rx_ovs_q == OVS_MID) begin
                        rx_ovs_d = '0;
                        rx_bit_d = '0;
                        rx_st_d = rx_sync_q ? S_IDLE : S_DATA;
                    end
                end
            end
            S_DATA: begin
                if (tick) begin
                    rx_ovs_d = rx_ovs_q + 1'b1;
                    if (rx_ovs_q == OVS_LAST) begin
                        rx_sh_d = {rx_sync_q, rx_sh_q[7:1]};
                        rx_bit_d = rx_bit_q + 1'b1;
                        if (rx_bit_q == BIT_LAST - 1'b1) begin
                            rx_st_d = S_STOP;
                        end
                    end
                end
            end
            S_STOP: begin
                if (tick) begin
                    rx_ovs_d = rx_ovs_q + 1'b1;
                    if (rx_ovs_q == OVS_LAST) begin
                        rx_st_d = S_IDLE;
                        push = rx_sync_q;
                        fe_d = !rx_sync_q;
                    end
                end
            end
            default: begin
                rx_st_d = S_IDLE;
            end
        endcase
    end

    // Single-byte holding register and output stage.
    always_comb begin
        hold_d = hold_q;
        hold_v_d = hold_v_q;
        ov_d = 1'b0;
        take = !out_v_q || rx_ready_i;
        if (!buffered_i && push) begin
            if (hold_v_q) begin
                ov_d = 1'b1;
            end
            hold_d = rx_sh_q;
            hold_v_d = 1'b1;
        end else if (buffered_i && push && !fifo_ready) begin
            ov_d = 1'b1;
        end
        out_d = out_q;
        out_v_d = out_v_q && !rx_ready_i;
        if (take && buffered_i && fifo_valid) begin
            out_d = fifo_data;
            out_v_d = 1'b1;
        end else if (take && hold_v_q && !(!buffered_i && push)) begin
            out_d = hold_q;
            out_v_d = 1'b1;
            hold_v_d = 1'b0;
        end
    end

    byte_fifo #(
        .WIDTH(DATA_BITS),
        .DEPTH(FIFO_DEPTH)
    ) rx_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .in_data_i(rx_sh_q),
        .in_valid_i(buffered_i && push),
        .in_ready_o(fifo_ready),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(take && buffered_i)
    );

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= '0;
            tx_st_q <= S_IDLE;
            tx_ovs_q <= '0;
            tx_bit_q <= '0;
            tx_sh_q <= BYTE_RST;
            tx_line_q <= 1'b1;
            tx_rdy_q <= 1'b1;
            drive_q <= 1'b0;
            rx_st_q <= S_IDLE;
            rx_ovs_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q <= BYTE_RST;
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            fe_q <= 1'b0;
            ov_q <= 1'b0;
            hold_q <= BYTE_RST;
            hold_v_q <= 1'b0;
            out_q <= BYTE_RST;
            out_v_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tx_st_q <= tx_st_d;
            tx_ovs_q <= tx_ovs_d;
            tx_bit_q <= tx_bit_d;
            tx_sh_q <= tx_sh_d;
            tx_line_q <= tx_line_d;
            tx_rdy_q <= tx_rdy_d;
            drive_q <= drive_d;
            rx_st_q <= rx_st_d;
            rx_ovs_q <= rx_ovs_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q <= rx_sh_d;
            rx_meta_q <= rx_line_i;
            rx_sync_q <= rx_meta_q;
            fe_q <= fe_d;
            ov_q <= ov_d;
            hold_q <= hold_d;
            hold_v_q <= hold_v_d;
            out_q <= out_d;
            out_v_q <= out_v_d;
        end
    end

    assign tx_line_o = tx_line_q;
    assign tx_drive_o = drive_q;
    assign tx_ready_o = tx_rdy_q;
    assign rx_data_o = out_q;
    assign rx_valid_o = out_v_q;
    assign frame_err_o = fe_q;
    assign overrun_o = ov_q;
endmodule

/* testbench/serial_port_sva.sv */
// Checker for the serial port's pin and handshake behaviour.
`timescale 1ns/100ps
module serial_port_sva (
    // Clock, reset and inputs.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic slave_mode_i,
    input wire logic turn_i,
    input wire logic tx_valid_i,
    input wire logic rx_ready_i,
    // Outputs.
    input wire logic tx_line_o,
    input wire logic tx_drive_o,
    input wire logic tx_ready_o,
    input wire logic [7:0] rx_data_o,
    input wire logic rx_valid_o,
    input wire logic frame_err_o,
    input wire logic overrun_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence take_s;
        tx_valid_i && tx_ready_o;
    endsequence
    sequence start_s;
        !tx_ready_o ##1 !tx_line_o;
    endsequence
    reset_idle_a: assert property (disable iff (1'b0) !rst_n_i |->
        tx_line_o && !tx_drive_o && tx_ready_o && !rx_valid_o) else $error("Not idle in reset.");
    start_bit_a: assert property (take_s |=> start_s) else $error("No start bit.");
    start_hold_a: assert property ($fell(tx_ready_o) |=>
        !tx_line_o [*8]) else $error("Start bit too short.");
    idle_high_a: assert property (tx_ready_o |-> tx_line_o) else $error("Idle line low.");
    slave_turn_a: assert property (slave_mode_i && $past(slave_mode_i) && $past(rst_n_i)
        |-> tx_drive_o == $past(turn_i)) else $error("Drive not following turn.");
    master_drive_a: assert property (!slave_mode_i && $past(!slave_mode_i) &&
        !tx_ready_o && $past(!tx_ready_o) |-> tx_drive_o) else $error("Driver off in frame.");
    frame_drop_a: assert property (frame_err_o && !rx_valid_o |=>
        !frame_err_o && !rx_valid_o ##1 !rx_valid_o) else $error("Bad frame kept.");
    rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=>
        rx_valid_o && (overrun_o || $stable(rx_data_o))) else $error("Held byte lost.");
endmodule
bind rs485_async_serial_port serial_port_sva u_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .slave_mode_i(slave_mode_i), .turn_i(turn_i), .tx_valid_i(tx_valid_i),
    .rx_ready_i(rx_ready_i), .tx_line_o(tx_line_o), .tx_drive_o(tx_drive_o),
    .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .frame_err_o(frame_err_o), .overrun_o(overrun_o));

/* testbench/serial_node.sv */
// Remote node on the serial link that sends and receives framed bytes.
`timescale 1ns/100ps
module serial_node #(
    parameter int BIT = 800
) (
    input wire logic sys_clk_i,
    input wire logic line_i,
    output logic line_o
);
    logic [8:0] sh;
    logic [7:0] got;
    logic stop_ok;
    int n_got = 0;
    initial line_o = 1'b1;
    // Start low, data least significant bit first, then the stop level.
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] fr;
        fr = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_o <= fr[i];
            repeat (BIT) @(posedge sys_clk_i);
        end
        if (!stop) begin
            line_o <= 1'b1;
            repeat (BIT) @(posedge sys_clk_i);
        end
    endtask
    // Samples each bit at its middle and needs no direction line.
    initial begin
        forever begin
            @(negedge line_i);
            repeat (BIT / 2) @(posedge sys_clk_i);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT) @(posedge sys_clk_i);
                sh = {line_i, sh[8:1]};
            end
            got = sh[7:0];
            stop_ok = sh[8];
            n_got++;
        end
    end
endmodule

/* testbench/rs485_async_serial_port_tb.sv */
// Self-checking testbench for the serial port.
`timescale 1ns/100ps
module rs485_async_serial_port_tb;
    import serial_port_pkg::*;
    typedef struct packed {logic [7:0] to_port; logic [7:0] from_port;} row_t;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b1, buffered_i = 1'b0, slave_mode_i = 1'b0;
    logic turn_i = 1'b0, tx_valid_i = 1'b0, rx_ready_i = 1'b0, fe_seen = 1'b0, ov_seen = 1'b0;
    logic rx_line_i, tx_line_o, tx_drive_o, tx_ready_o, rx_valid_o, frame_err_o, overrun_o;
    logic [7:0] tx_data_i = 8'h00;
    logic [7:0] rx_data_o;
    logic [DIV_W-1:0] baud_div_i = DIV_MIN;
    int n_fail = 0, num_checks = 0, cyc = 0, k, m;
    row_t rows [3] = '{'{8'h01, 8'h80}, '{8'ha5, 8'h5a}, '{8'hff, 8'h00}};
    rs485_async_serial_port u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .baud_div_i(baud_div_i), .buffered_i(buffered_i), .slave_mode_i(slave_mode_i),
        .rx_line_i(rx_line_i), .tx_line_o(tx_line_o), .tx_drive_o(tx_drive_o),
        .turn_i(turn_i), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
        .rx_ready_i(rx_ready_i), .frame_err_o(frame_err_o), .overrun_o(overrun_o));
    serial_node #(.BIT(16 * int'(DIV_MIN))) u_node (.sys_clk_i(sys_clk_i),
        .line_i(tx_line_o), .line_o(rx_line_i));
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic put_tx(input logic [7:0] b);
        @(posedge sys_clk_i);
        tx_data_i <= b;
        tx_valid_i <= 1'b1;
        do @(posedge sys_clk_i); while (tx_ready_o !== 1'b1);
        tx_valid_i <= 1'b0;
    endtask
    task automatic take_rx(input logic [7:0] exp);
        k = 0;
        while (rx_valid_o !== 1'b1 && k < 20000) begin
            @(posedge sys_clk_i);
            k++;
        end
        chk("rx_data", rx_data_o, exp);
        rx_ready_i <= 1'b1;
        @(posedge sys_clk_i);
        rx_ready_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    always @(posedge sys_clk_i) begin
        cyc++;
        if (frame_err_o === 1'b1)
            fe_seen <= 1'b1;
        if (overrun_o === 1'b1)
            ov_seen <= 1'b1;
        if (cyc == 95000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        rst_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        foreach (rows[i]) begin
            m = u_node.n_got;
            fork
                put_tx(rows[i].to_port);
                @(posedge sys_clk_i) u_node.send(rows[i].from_port, 1'b1);
            join
            take_rx(rows[i].from_port);
            for (int j = 0; j < 4000 && u_node.n_got == m; j++) @(posedge sys_clk_i);
            chk("node_data", u_node.got, rows[i].to_port);
            chk("node_stop", {7'h00, u_node.stop_ok}, 8'h01);
        end
        u_node.send(8'h11, 1'b1);
        u_node.send(8'h22, 1'b1);
        u_node.send(8'h33, 1'b1);
        chk("overrun", {7'h00, ov_seen}, 8'h01);
        take_rx(8'h11);
        take_rx(8'h33);
        buffered_i <= 1'b1;
        @(posedge sys_clk_i);
        u_node.send(8'h3c, 1'b1);
        u_node.send(8'hc3, 1'b1);
        take_rx(8'h3c);
        take_rx(8'hc3);
        u_node.send(8'h55, 1'b0);
        chk("frame_err", {7'h00, fe_seen}, 8'h01);
        chk("rx_valid", {7'h00, rx_valid_o}, 8'h00);
        buffered_i <= 1'b0;
        slave_mode_i <= 1'b1;
        turn_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        chk("tx_drive", {7'h00, tx_drive_o}, 8'h01);
        turn_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        chk("tx_drive", {7'h00, tx_drive_o}, 8'h00);
        slave_mode_i <= 1'b0;
        put_tx(8'h0f);
        repeat (100) @(posedge sys_clk_i);
        chk("tx_drive", {7'h00, tx_drive_o}, 8'h01);
        chk("tx_line", {7'h00, tx_line_o}, 8'h00);
        rst_n_i <= 1'b0;
        @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        chk("tx_line", {7'h00, tx_line_o}, 8'h01);
        chk("tx_ready", {7'h00, tx_ready_o}, 8'h01);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        chk("tx_ready", {7'h00, tx_ready_o}, 8'h01);
        chk("rx_valid", {7'h00, rx_valid_o}, 8'h00);
        chk("tx_drive", {7'h00, tx_drive_o}, 8'h00);
        chk("tx_line", {7'h00, tx_line_o}, 8'h01);
        report_and_stop();
    end
endmodule
